// ===== hw/ipp_hold.sv
// 32-bit holding register that feeds the pipe and answers sequential fetches
`timescale 1ns/10ps
module ipp_hold
  import ipp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic inval_i,
  input wire logic load_i,
  input wire logic [29:0] load_tag_i,
  input wire logic [31:0] load_data_i,
  input wire logic load_fault_i,
  input wire logic [30:0] look_addr_i,
  output logic hit_o,
  output logic [15:0] word_o,
  output logic fault_o,
  output logic valid_o,
  output logic [31:0] data_o
);

  ipp_hold_st_t q, d;

  // next state: invalidate beats a load in the same cycle
  always_comb begin
    d = q;
    if (inval_i) begin
      d.valid = 1'b0;
    end else if (load_i) begin
      d.valid = 1'b1;
      d.fault = load_fault_i;
      d.tag = load_tag_i;
      d.data = load_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // lookup runs beside the cache and the bus; odd word is the low half
  assign hit_o = q.valid & (q.tag == look_addr_i[30:1]);
  assign word_o = look_addr_i[0] ? q.data[15:0] : q.data[31:16];
  assign fault_o = q.fault;
  assign valid_o = q.valid;
  assign data_o = q.data;

endmodule

// ===== hw/ipp_params.svh
// constants for the instruction prefetch pipe and processing-state block
`ifndef IPP_PARAMS_SVH
`define IPP_PARAMS_SVH

// register byte offsets on the control bus
`define IPP_OFS_CTRL 8'h00
`define IPP_OFS_STAT 8'h04
`define IPP_OFS_PIPE_DC 8'h08
`define IPP_OFS_PIPE_B 8'h0c
`define IPP_OFS_HOLD 8'h10

// control register fields and reset values
`define IPP_CTRL_CEN_BIT 0
`define IPP_CTRL_SUP_BIT 1
`define IPP_RST_CEN 1'b0
`define IPP_RST_SUP 1'b1

// status register field positions
`define IPP_STAT_STATE_LSB 0
`define IPP_STAT_PVLD_LSB 4
`define IPP_STAT_PFLT_LSB 7
`define IPP_STAT_SUP_BIT 10
`define IPP_STAT_HVLD_BIT 11
`define IPP_STAT_PEND_BIT 12

// function code values for program fetches
`define IPP_FC_SUP_PROG 3'h6
`define IPP_FC_USR_PROG 3'h2

// bus responses
`define IPP_RESP_OKAY 2'h0
`define IPP_RESP_SLVERR 2'h2

// pipe geometry
`define IPP_STAGE_W 16
`define IPP_PIPE_DEPTH 3

`endif

// ===== hw/ipp_pipe.sv
// instruction pipe: words enter at the first stage and shift toward the last
`timescale 1ns/10ps
module ipp_pipe
  import ipp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] word_i,
  input wire logic fault_i,
  output logic [DEPTH-1:0][WIDTH-1:0] words_o,
  output logic [DEPTH-1:0] valid_o,
  output logic [DEPTH-1:0] fault_o
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0] flt;
  } ipp_pipe_st_t;

  ipp_pipe_st_t q, d;

  // stage 0 is B, the last stage is D where decode completes
  always_comb begin
    d = q;
    if (flush_i) begin
      d.vld = '0;
    end else if (load_i) begin
      d.word[0] = word_i;
      d.vld[0] = 1'b1;
      d.flt[0] = fault_i;
      for (int i = 1; i < DEPTH; i++) begin
        d.word[i] = q.word[i-1];
        d.vld[i] = q.vld[i-1];
        d.flt[i] = q.flt[i-1];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign words_o = q.word;
  assign valid_o = q.vld;
  assign fault_o = q.flt;

endmodule

// ===== hw/ipp_pkg.sv
// types shared by the prefetch pipe block
package ipp_pkg;

  // processing states, one-hot
  typedef enum logic [3:0] {
    IPP_ST_NORMAL = 4'b0001,
    IPP_ST_EXCEPT = 4'b0010,
    IPP_ST_HALTED = 4'b0100,
    IPP_ST_STOPPED = 4'b1000
  } ipp_state_t;

  // holding register state
  typedef struct packed {
    logic valid;
    logic fault;
    logic [29:0] tag;
    logic [31:0] data;
  } ipp_hold_st_t;

  // top-level state
  typedef struct packed {
    ipp_state_t state;
    logic sup;
    logic cache_en;
    logic pending;
    logic [30:0] pf_addr;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipp_top_st_t;

endpackage

// ===== hw/ipp_top.sv
// prefetch front end, instruction pipe and processing-state control
`timescale 1ns/10ps
`include "ipp_params.svh"
module ipp_top
  import ipp_pkg::*;
#(
  parameter int STAGE_W = `IPP_STAGE_W,
  parameter int DEPTH = `IPP_PIPE_DEPTH
) (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // register bus
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [7:0] AWADDR_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [7:0] ARADDR_I,
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  // sequencer
  input wire logic PF_REQ_I,
  input wire logic [31:0] PF_ADDR_I,
  input wire logic PF_FLUSH_I,
  output logic PF_BUSY_O,
  output logic PF_DONE_O,
  output logic [STAGE_W-1:0] PIPE_D_O,
  output logic PIPE_D_VALID_O,
  output logic PIPE_D_FAULT_O,
  input wire logic IRQ_ACK_I,
  input wire logic TRACE_I,
  input wire logic TRAP_I,
  input wire logic CP_EXC_I,
  input wire logic BUS_ERR_I,
  input wire logic ADDR_ERR_I,
  input wire logic PRIV_INSTR_I,
  input wire logic SUP_ACCESS_I,
  input wire logic STOP_EXEC_I,
  input wire logic HANDLER_START_I,
  output logic [3:0] STATE_O,
  output logic SUP_O,
  // instruction cache
  output logic IC_REQ_O,
  input wire logic IC_HIT_I,
  input wire logic [31:0] IC_DATA_I,
  // bus controller
  output logic BUS_REQ_O,
  output logic BUS_ABORT_O,
  output logic [31:0] BUS_ADDR_O,
  output logic [2:0] FC_O,
  input wire logic BUS_DONE_I,
  input wire logic [31:0] BUS_DATA_I,
  input wire logic BUS_FAULT_I
);

  ipp_top_st_t q, d;

  logic hold_hit;
  logic [15:0] hold_word;
  logic hold_fault;
  logic hold_valid;
  logic [31:0] hold_data;
  logic [DEPTH-1:0][STAGE_W-1:0] pipe_words;
  logic [DEPTH-1:0] pipe_vld;
  logic [DEPTH-1:0] pipe_flt;

  logic flush;
  logic can_fetch;
  logic pf_fire;
  logic hold_serve;
  logic ic_take;
  logic bus_take;
  logic fill;
  logic [31:0] fill_data;
  logic fill_fault;
  logic [15:0] pipe_in;
  logic pipe_in_fault;
  logic [30:0] look_addr;
  logic aw_now;
  logic w_now;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic sw_sup_chg;
  logic err;
  logic priv_trap;
  logic exc_cause;
  logic exc_enter;
  logic halt_enter;
  logic stop_enter;

  // true when the offset names a mapped register
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == `IPP_OFS_CTRL) | (a == `IPP_OFS_STAT) |
                 (a == `IPP_OFS_PIPE_DC) | (a == `IPP_OFS_PIPE_B) |
                 (a == `IPP_OFS_HOLD);
  endfunction

  // read value for a register offset
  function automatic logic [31:0] reg_read(input logic [7:0] a, input ipp_top_st_t s,
                                           input logic [DEPTH-1:0] pv,
                                           input logic [DEPTH-1:0] pf,
                                           input logic hv, input logic [31:0] hd,
                                           input logic [DEPTH-1:0][STAGE_W-1:0] pw);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `IPP_OFS_CTRL: begin
        v[`IPP_CTRL_CEN_BIT] = s.cache_en;
        v[`IPP_CTRL_SUP_BIT] = s.sup;
      end
      `IPP_OFS_STAT: begin
        v[`IPP_STAT_STATE_LSB +: 4] = s.state;
        v[`IPP_STAT_PVLD_LSB +: 3] = pv[2:0];
        v[`IPP_STAT_PFLT_LSB +: 3] = pf[2:0];
        v[`IPP_STAT_SUP_BIT] = s.sup;
        v[`IPP_STAT_HVLD_BIT] = hv;
        v[`IPP_STAT_PEND_BIT] = s.pending;
      end
      `IPP_OFS_PIPE_DC: v = {pw[1][15:0], pw[2][15:0]};
      `IPP_OFS_PIPE_B: v = {16'h0000, pw[0][15:0]};
      `IPP_OFS_HOLD: v = hd;
      default: v = 32'h0000_0000;
    endcase
    reg_read = v;
  endfunction

  // fetches only run in normal or exception processing; stop and halt are bus-quiet
  assign can_fetch = (q.state == IPP_ST_NORMAL) | (q.state == IPP_ST_EXCEPT);
  assign look_addr = PF_ADDR_I[31:1];
  assign pf_fire = PF_REQ_I & can_fetch & ~q.pending & ~flush;
  assign hold_serve = pf_fire & hold_hit;
  assign ic_take = q.pending & q.cache_en & IC_HIT_I & ~flush;
  assign bus_take = q.pending & ~ic_take & BUS_DONE_I & ~flush;
  assign fill = ic_take | bus_take;
  assign fill_data = ic_take ? IC_DATA_I : BUS_DATA_I;
  assign fill_fault = bus_take & BUS_FAULT_I;

  // even word takes the upper half of the filled long word, odd the lower
  always_comb begin
    if (hold_serve) begin
      pipe_in = hold_word;
      pipe_in_fault = hold_fault;
    end else begin
      pipe_in = q.pf_addr[0] ? fill_data[15:0] : fill_data[31:16];
      pipe_in_fault = fill_fault;
    end
  end

  // write channel: address and data may arrive in either order
  assign aw_now = AWVALID_I & AWREADY_O;
  assign w_now = WVALID_I & WREADY_O;
  assign do_write = (q.aw_got | aw_now) & (q.w_got | w_now);
  assign wr_addr = q.aw_got ? q.awaddr : AWADDR_I;
  assign wr_data = q.w_got ? q.wdata : WDATA_I;
  assign wr_strb = q.w_got ? q.wstrb : WSTRB_I;
  assign sw_sup_chg = do_write & (wr_addr == `IPP_OFS_CTRL) & wr_strb[0] &
                      (wr_data[`IPP_CTRL_SUP_BIT] != q.sup);

  // exception causes; a privileged attempt at user level becomes a trap
  assign err = BUS_ERR_I | ADDR_ERR_I;
  assign priv_trap = (PRIV_INSTR_I | SUP_ACCESS_I | STOP_EXEC_I) & ~q.sup;
  assign exc_cause = IRQ_ACK_I | TRACE_I | TRAP_I | CP_EXC_I | err | priv_trap;
  assign exc_enter = exc_cause &
                     ((q.state == IPP_ST_NORMAL) | (q.state == IPP_ST_STOPPED));
  assign halt_enter = err & (q.state == IPP_ST_EXCEPT);
  assign stop_enter = (q.state == IPP_ST_NORMAL) & ~exc_cause & STOP_EXEC_I & q.sup;
  assign flush = PF_FLUSH_I | exc_enter | halt_enter | stop_enter | sw_sup_chg;

  // next state of the whole block
  always_comb begin
    d = q;
    // register bus write side
    if (aw_now) begin
      d.aw_got = 1'b1;
      d.awaddr = AWADDR_I;
    end
    if (w_now) begin
      d.w_got = 1'b1;
      d.wdata = WDATA_I;
      d.wstrb = WSTRB_I;
    end
    if (do_write) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = reg_mapped(wr_addr) ? `IPP_RESP_OKAY : `IPP_RESP_SLVERR;
      if ((wr_addr == `IPP_OFS_CTRL) & wr_strb[0]) begin
        d.cache_en = wr_data[`IPP_CTRL_CEN_BIT];
        d.sup = wr_data[`IPP_CTRL_SUP_BIT];
      end
    end else if (q.bvalid & BREADY_I) begin
      d.bvalid = 1'b0;
    end
    // register bus read side
    if (ARVALID_I & ARREADY_O) begin
      d.rvalid = 1'b1;
      d.rdata = reg_read(ARADDR_I, q, pipe_vld, pipe_flt, hold_valid, hold_data, pipe_words);
      d.rresp = reg_mapped(ARADDR_I) ? `IPP_RESP_OKAY : `IPP_RESP_SLVERR;
    end else if (q.rvalid & RREADY_I) begin
      d.rvalid = 1'b0;
    end
    // prefetch tracking; a flush drops an outstanding fill
    if (flush | fill) begin
      d.pending = 1'b0;
    end else if (pf_fire & ~hold_hit) begin
      d.pending = 1'b1;
      d.pf_addr = PF_ADDR_I[31:1];
    end
    // processing states; hardware entry to supervisor wins over a software write
    case (q.state)
      IPP_ST_NORMAL: begin
        if (exc_cause) begin
          d.state = IPP_ST_EXCEPT;
          d.sup = 1'b1;
        end else if (stop_enter) begin
          d.state = IPP_ST_STOPPED;
        end
      end
      IPP_ST_EXCEPT: begin
        if (err) begin
          d.state = IPP_ST_HALTED;
        end else if (HANDLER_START_I) begin
          d.state = IPP_ST_NORMAL;
        end
      end
      IPP_ST_STOPPED: begin
        if (exc_cause) begin
          d.state = IPP_ST_EXCEPT;
          d.sup = 1'b1;
        end
      end
      IPP_ST_HALTED: begin
        d.state = IPP_ST_HALTED;
      end
      default: begin
        d.state = IPP_ST_HALTED;
      end
    endcase
  end

  // only reset leaves the halted state
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= '0;
      q.state <= IPP_ST_NORMAL;
      q.sup <= `IPP_RST_SUP;
      q.cache_en <= `IPP_RST_CEN;
    end else begin
      q <= d;
    end
  end

  // holding register, invalidated together with the pipe
  ipp_hold u_hold (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .inval_i(flush),
    .load_i(fill),
    .load_tag_i(q.pf_addr[30:1]),
    .load_data_i(fill_data),
    .load_fault_i(fill_fault),
    .look_addr_i(look_addr),
    .hit_o(hold_hit),
    .word_o(hold_word),
    .fault_o(hold_fault),
    .valid_o(hold_valid),
    .data_o(hold_data)
  );

  ipp_pipe #(
    .WIDTH(STAGE_W),
    .DEPTH(DEPTH)
  ) u_pipe (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .flush_i(flush),
    .load_i(hold_serve | fill),
    .word_i(pipe_in[STAGE_W-1:0]),
    .fault_i(pipe_in_fault),
    .words_o(pipe_words),
    .valid_o(pipe_vld),
    .fault_o(pipe_flt)
  );

  // register bus handshakes; one write and one read in flight at a time
  assign AWREADY_O = ~q.aw_got & ~q.bvalid;
  assign WREADY_O = ~q.w_got & ~q.bvalid;
  assign BVALID_O = q.bvalid;
  assign BRESP_O = q.bresp;
  assign ARREADY_O = ~q.rvalid;
  assign RVALID_O = q.rvalid;
  assign RDATA_O = q.rdata;
  assign RRESP_O = q.rresp;

  // sequencer side: only the last stage counts as a decoded word
  assign PF_BUSY_O = q.pending;
  assign PF_DONE_O = hold_serve | fill;
  assign PIPE_D_O = pipe_words[DEPTH-1];
  assign PIPE_D_VALID_O = pipe_vld[DEPTH-1];
  assign PIPE_D_FAULT_O = pipe_flt[DEPTH-1];
  assign STATE_O = q.state;
  assign SUP_O = q.sup;

  // a request goes to cache and bus at once; a hold hit kills the bus cycle
  assign IC_REQ_O = pf_fire & q.cache_en;
  assign BUS_REQ_O = pf_fire | q.pending;
  assign BUS_ABORT_O = hold_serve | ic_take | (q.pending & flush);
  assign BUS_ADDR_O = q.pending ? {q.pf_addr[30:1], 2'b00} : {PF_ADDR_I[31:2], 2'b00};
  assign FC_O = q.sup ? `IPP_FC_SUP_PROG : `IPP_FC_USR_PROG;

endmodule

// ===== sim/ipp_chk.sv
// concurrent checks on the ports of the prefetch pipe block
`timescale 1ns/10ps
`include "ipp_params.svh"
module ipp_chk
  import ipp_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic PF_FLUSH_I,
  input wire logic TRAP_I,
  input wire logic PRIV_INSTR_I,
  input wire logic HANDLER_START_I,
  input wire logic BUS_ERR_I,
  input wire logic ADDR_ERR_I,
  input wire logic [3:0] STATE_O,
  input wire logic SUP_O,
  input wire logic [2:0] FC_O,
  input wire logic IC_REQ_O,
  input wire logic BUS_REQ_O,
  input wire logic BUS_ABORT_O,
  input wire logic [31:0] BUS_ADDR_O,
  input wire logic PF_BUSY_O,
  input wire logic PIPE_D_VALID_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // state moves, each tied to its cause one edge earlier; the function code is checked against the privilege level in the same cycle
  a_halt_sticky: assert property (STATE_O == IPP_ST_HALTED |=> STATE_O == IPP_ST_HALTED)
    else $error("halted state left without reset");
  a_err_halts: assert property (STATE_O == IPP_ST_EXCEPT && (BUS_ERR_I || ADDR_ERR_I) |=> STATE_O == IPP_ST_HALTED)
    else $error("error in exception did not halt");
  a_trap_entry: assert property (STATE_O == IPP_ST_NORMAL && TRAP_I |=> STATE_O == IPP_ST_EXCEPT && SUP_O)
    else $error("trap did not enter exception at supervisor level");
  a_handler_end: assert property (STATE_O == IPP_ST_EXCEPT && HANDLER_START_I && !BUS_ERR_I && !ADDR_ERR_I |=> STATE_O == IPP_ST_NORMAL)
    else $error("handler start did not end exception");
  a_user_trap: assert property (STATE_O == IPP_ST_NORMAL && !SUP_O && PRIV_INSTR_I |=> STATE_O == IPP_ST_EXCEPT)
    else $error("privileged attempt at user level not trapped");
  a_fc_level: assert property (FC_O == (SUP_O ? `IPP_FC_SUP_PROG : `IPP_FC_USR_PROG))
    else $error("function code disagrees with privilege level");
  // fetch side: cache and bus see the same request
  a_ic_bus_par: assert property (IC_REQ_O |-> BUS_REQ_O)
    else $error("cache request without bus request");
  a_abort_req: assert property (BUS_ABORT_O |-> BUS_REQ_O)
    else $error("abort without a bus request");
  a_stop_quiet: assert property (STATE_O == IPP_ST_STOPPED && !PF_BUSY_O |-> !BUS_REQ_O)
    else $error("bus request while stopped");
  a_flush_pipe: assert property (PF_FLUSH_I |=> !PIPE_D_VALID_O)
    else $error("pipe still valid after flush");
  a_long_align: assert property (BUS_REQ_O |-> BUS_ADDR_O[1:0] == 2'h0)
    else $error("bus address not long-word aligned");
  c_halted: cover property (STATE_O == IPP_ST_HALTED);
  c_stopped: cover property (STATE_O == IPP_ST_STOPPED);
  c_abort: cover property (BUS_ABORT_O && !PF_FLUSH_I);
endmodule
bind ipp_top ipp_chk u_chk (.*);

// ===== sim/ipp_mem.sv
// stand-in for the instruction cache and the external bus controller
`timescale 1ns/10ps
module ipp_mem
  import ipp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_req_i,
  input wire logic bus_abort_i,
  input wire logic [31:0] bus_addr_i,
  input wire logic ic_req_i,
  input wire logic hit_en_i,
  input wire logic flt_i,
  input wire logic [1:0] dly_i,
  output logic bus_done_o,
  output logic [31:0] bus_data_o,
  output logic bus_fault_o,
  output logic ic_hit_o,
  output logic [31:0] ic_data_o
);
  logic [2:0] cnt;
  logic fin;
  logic ich;
  function automatic logic [31:0] lw(input logic [31:0] x);
    return {~x[15:0], x[15:0] ^ 16'h5a5a};
  endfunction
  // a cycle ends after dly_i+1 clocks; abort or dropped request kills it at once
  assign fin = bus_req_i && !bus_abort_i && !bus_done_o && cnt == {1'h0, dly_i};
  assign ich = ic_req_i && hit_en_i;
  // idle data lines toggle so a stale word is never mistaken for a fresh one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
      bus_done_o <= 1'h0;
      bus_data_o <= 32'h0;
      bus_fault_o <= 1'h0;
      ic_hit_o <= 1'h0;
      ic_data_o <= 32'h0;
    end else begin
      cnt <= (!bus_req_i || bus_abort_i || bus_done_o) ? 3'h0 : cnt + 3'h1;
      bus_done_o <= fin;
      bus_fault_o <= fin && flt_i;
      bus_data_o <= fin ? lw(bus_addr_i) : ~bus_data_o;
      ic_hit_o <= ich;
      ic_data_o <= ich ? lw(bus_addr_i) : ~ic_data_o;
    end
  end
endmodule

// ===== sim/test_ipp_top.sv
// self-checking bench for the prefetch pipe and processing states
`timescale 1ns/10ps
`include "ipp_params.svh"
module test_ipp_top
  import ipp_pkg::*;
;
  logic REF_CLK_I = 1'h0;
  logic RST_I = 1'h1;
  logic AWVALID_I = 1'h0, WVALID_I = 1'h0, BREADY_I = 1'h0, ARVALID_I = 1'h0, RREADY_I = 1'h0;
  logic [7:0] AWADDR_I = 8'h0, ARADDR_I = 8'h0;
  logic [31:0] WDATA_I = 32'h0, PF_ADDR_I = 32'h0;
  logic [3:0] WSTRB_I = 4'h0;
  logic PF_REQ_I = 1'h0, PF_FLUSH_I = 1'h0, hit_en = 1'h0, flt = 1'h0, cen = 1'h0;
  logic [9:0] ev = 10'h0;
  logic [1:0] dly = 2'h0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, PF_BUSY_O, PF_DONE_O, SUP_O;
  logic PIPE_D_VALID_O, PIPE_D_FAULT_O, IC_REQ_O, IC_HIT_I, BUS_REQ_O, BUS_ABORT_O;
  logic BUS_DONE_I, BUS_FAULT_I;
  logic [1:0] BRESP_O, RRESP_O, rs;
  logic [31:0] RDATA_O, IC_DATA_I, BUS_ADDR_O, BUS_DATA_I, rd, a, e;
  logic [15:0] PIPE_D_O;
  logic [3:0] STATE_O;
  logic [2:0] FC_O;
  int fails = 0;
  int n_tests = 0;
  ipp_top DUT (.*, .IRQ_ACK_I(ev[0]), .TRACE_I(ev[1]), .TRAP_I(ev[2]), .CP_EXC_I(ev[3]),
    .BUS_ERR_I(ev[4]), .ADDR_ERR_I(ev[5]), .PRIV_INSTR_I(ev[6]), .SUP_ACCESS_I(ev[7]),
    .STOP_EXEC_I(ev[8]), .HANDLER_START_I(ev[9]));
  ipp_mem u_mem (.clk_i(REF_CLK_I), .rst_i(RST_I), .bus_req_i(BUS_REQ_O),
    .bus_abort_i(BUS_ABORT_O), .bus_addr_i(BUS_ADDR_O), .ic_req_i(IC_REQ_O),
    .hit_en_i(hit_en), .flt_i(flt), .dly_i(dly), .bus_done_o(BUS_DONE_I),
    .bus_data_o(BUS_DATA_I), .bus_fault_o(BUS_FAULT_I), .ic_hit_o(IC_HIT_I),
    .ic_data_o(IC_DATA_I));
  // free-running 100 MHz clock
  initial begin
    forever #5 REF_CLK_I = ~REF_CLK_I;
  end
  function automatic logic [31:0] lw(input logic [31:0] x);
    return {~x[15:0], x[15:0] ^ 16'h5a5a};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up(input int n);
    if (n > 50) begin
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  // ready and valid are sampled half a cycle early, so the edge's own updates never race
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'h0;
    AWVALID_I <= 1'h1;
    AWADDR_I <= ad;
    WVALID_I <= 1'h1;
    WDATA_I <= d;
    WSTRB_I <= 4'hf;
    BREADY_I <= 1'h1;
    while (!b) begin
      @(negedge REF_CLK_I);
      aw = AWVALID_I && AWREADY_O;
      w = WVALID_I && WREADY_O;
      b = BVALID_O;
      r = BRESP_O;
      @(posedge REF_CLK_I);
      if (aw) AWVALID_I <= 1'h0;
      if (w) WVALID_I <= 1'h0;
      if (b) BREADY_I <= 1'h0;
      n++;
      give_up(n);
    end
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, v;
    n = 0;
    v = 1'h0;
    ARVALID_I <= 1'h1;
    ARADDR_I <= ad;
    RREADY_I <= 1'h1;
    while (!v) begin
      @(negedge REF_CLK_I);
      ar = ARVALID_I && ARREADY_O;
      v = RVALID_O;
      d = RDATA_O;
      r = RRESP_O;
      @(posedge REF_CLK_I);
      // rready stays up after the answer, so back-to-back reads never drive it twice at once
      if (ar) ARVALID_I <= 1'h0;
      n++;
      give_up(n);
    end
  endtask
  // one prefetch; a hit must finish in its own cycle and abort the bus
  task automatic pf(input logic [31:0] ad, input logic hit);
    int n;
    n = 0;
    PF_REQ_I <= 1'h1;
    PF_ADDR_I <= ad;
    @(negedge REF_CLK_I);
    check(BUS_REQ_O, 32'h1);
    check(BUS_ABORT_O, {31'h0, hit});
    check(PF_DONE_O, {31'h0, hit});
    check(IC_REQ_O, {31'h0, cen});
    @(posedge REF_CLK_I);
    PF_REQ_I <= 1'h0;
    if (!hit) begin
      do begin
        @(negedge REF_CLK_I);
        n++;
        give_up(n);
      end while (!PF_DONE_O);
    end
    // one edge passes on a hit too, so the request drops before the next call raises it
    @(posedge REF_CLK_I);
  endtask
  // event pulse, then privilege bit and state one edge later
  task automatic evp(input logic [9:0] v, input logic [3:0] st);
    ev <= v;
    @(posedge REF_CLK_I);
    ev <= 10'h0;
    @(negedge REF_CLK_I);
    check({SUP_O, STATE_O}, {27'h0, 1'h1, st});
    @(posedge REF_CLK_I);
  endtask
  initial begin
    a = $urandom(32'h58eb);
    repeat (4) @(posedge REF_CLK_I);
    RST_I <= 1'h0;
    @(negedge REF_CLK_I);
    check({SUP_O, FC_O, STATE_O}, {24'h0, 1'h1, `IPP_FC_SUP_PROG, IPP_ST_NORMAL});
    @(posedge REF_CLK_I);
    axi_rd(`IPP_OFS_CTRL, rd, rs);
    check(rd[1:0], {1'h1, 1'h0});
    axi_rd(8'h20, rd, rs);
    check(rs, `IPP_RESP_SLVERR);
    // even miss, odd hit from the holding register, even miss; first word reaches D
    for (int i = 0; i < 8; i++) begin
      cen = i[0];
      axi_wr(`IPP_OFS_CTRL, {30'h0, 1'h1, cen}, rs);
      check(rs, `IPP_RESP_OKAY);
      axi_rd(`IPP_OFS_CTRL, rd, rs);
      check(rd[1:0], {1'h1, cen});
      hit_en <= (i == 7) ? 1'h0 : 1'($urandom);
      dly <= 2'($urandom);
      flt <= (i == 7);
      a = $urandom & 32'h0000fff8;
      e = lw(a);
      PF_FLUSH_I <= 1'h1;
      @(posedge REF_CLK_I);
      PF_FLUSH_I <= 1'h0;
      pf(a, 1'h0);
      pf(a + 32'h2, 1'h1);
      pf(a + 32'h4, 1'h0);
      @(negedge REF_CLK_I);
      check({PIPE_D_O, PIPE_D_VALID_O, PIPE_D_FAULT_O}, {14'h0, e[31:16], 1'h1, flt});
      @(posedge REF_CLK_I);
      // stage C holds the low half served from the holding register, D the high half
      axi_rd(`IPP_OFS_PIPE_DC, rd, rs);
      check(rd, {e[15:0], e[31:16]});
      axi_rd(`IPP_OFS_STAT, rd, rs);
      check(rd[12:0], {3'h3, {3{flt}}, 3'h7, IPP_ST_NORMAL});
      axi_rd(`IPP_OFS_HOLD, rd, rs);
      check(rd, lw(a + 32'h4));
    end
    flt <= 1'h0;
    axi_wr(`IPP_OFS_CTRL, 32'h0, rs);
    @(negedge REF_CLK_I);
    check({SUP_O, FC_O}, {28'h0, 1'h0, `IPP_FC_USR_PROG});
    @(posedge REF_CLK_I);
    evp(10'h040, IPP_ST_EXCEPT);
    evp(10'h200, IPP_ST_NORMAL);
    for (int i = 0; i < 6; i++) begin
      evp(10'h1 << i, IPP_ST_EXCEPT);
      evp(10'h200, IPP_ST_NORMAL);
    end
    evp(10'h100, IPP_ST_STOPPED);
    PF_REQ_I <= 1'h1;
    @(negedge REF_CLK_I);
    check(BUS_REQ_O, 32'h0);
    @(posedge REF_CLK_I);
    PF_REQ_I <= 1'h0;
    evp(10'h004, IPP_ST_EXCEPT);
    evp(10'h020, IPP_ST_HALTED);
    evp(10'h204, IPP_ST_HALTED);
    RST_I <= 1'h1;
    @(posedge REF_CLK_I);
    RST_I <= 1'h0;
    @(negedge REF_CLK_I);
    check({SUP_O, FC_O, STATE_O}, {24'h0, 1'h1, `IPP_FC_SUP_PROG, IPP_ST_NORMAL});
    wrap_up();
  end
endmodule
